// file: sccg_pkg.sv
// Constants, register map and mode codes shared by both ends of the
// sleep and clock gating controller.
// Assumes a single 50 MHz system clock drives both ends.
package sccg_pkg;

	// Register offsets on the core's I/O register port
	localparam logic [5:0] SCCG_TRIM_OFS = 6'h31;
	localparam logic [5:0] SCCG_CTRL_OFS = 6'h35;

	// Fields of mcu_control_reg
	localparam int SCCG_ARM_BIT = 7;
	localparam int SCCG_MODE_LSB = 4;
	localparam int SCCG_MODE_MSB = 6;
	localparam logic [7:0] SCCG_CTRL_RST = 8'h00;
	localparam logic [7:0] SCCG_TRIM_RST = 8'h00;
	localparam logic [7:0] SCCG_CTRL_MASK = 8'hF0;

	// Trim steps that stand for 10 % above nominal
	localparam logic [7:0] SCCG_TRIM_FAST_MARGIN = 8'h19;

	// Wake-up timing, in cycles of the restarted clock
	localparam logic [10:0] SCCG_HALT_CK = 11'h004;
	localparam logic [10:0] SCCG_STANDBY_CK = 11'h006;
	localparam logic [10:0] SCCG_FAST_CK = 11'h006;
	localparam logic [10:0] SCCG_EXTRC_CK = 11'h012;
	localparam logic [10:0] SCCG_XTAL_CK = 11'h400;

	// clock_select_fuses codes
	localparam logic [3:0] SCCG_FUSE_RC_LAST = 4'h4;
	localparam logic [3:0] SCCG_FUSE_EXTRC_LAST = 4'h8;

	// Sleep mode select codes
	typedef enum logic [2:0] {
		SCCG_IDLE = 3'b000,
		SCCG_ADC_NR = 3'b001,
		SCCG_PWR_DOWN = 3'b010,
		SCCG_PWR_SAVE = 3'b011,
		SCCG_RSV4 = 3'b100,
		SCCG_RSV5 = 3'b101,
		SCCG_STANDBY = 3'b110,
		SCCG_EXT_STANDBY = 3'b111
	} sccg_mode_t;

	// Clock restart delay after a power-down style wake
	function automatic logic [10:0] sccg_restart_ck(input logic [3:0] fuses);
		logic [10:0] ck;
		ck = SCCG_XTAL_CK;
		if (fuses <= SCCG_FUSE_RC_LAST) begin
			ck = SCCG_FAST_CK;
		end else if (fuses <= SCCG_FUSE_EXTRC_LAST) begin
			ck = SCCG_EXTRC_CK;
		end
		return ck;
	endfunction

endpackage

// file: sccg_link_if.sv
// Link between the CPU core end and the sleep controller end.
// Both ends run on the same system clock; no clocking block is used.
`timescale 1ns/1ns
interface sccg_link_if;
	logic [5:0] io_addr;
	logic [7:0] io_wdata;
	logic io_wr;
	logic io_rd;
	logic [7:0] io_rdata;
	logic io_rvalid;
	logic sleep_instr;
	logic irq_global_en;
	logic core_halt;
	logic handler_go;
	logic [7:0] factory_trim;
	logic timer_async;

	modport dev (
		input io_addr, io_wdata, io_wr, io_rd, sleep_instr, irq_global_en,
		output io_rdata, io_rvalid, core_halt, handler_go, factory_trim,
		output timer_async
	);

	modport core (
		output io_addr, io_wdata, io_wr, io_rd, sleep_instr, irq_global_en,
		input io_rdata, io_rvalid, core_halt, handler_go, factory_trim,
		input timer_async
	);
endinterface

// file: sccg_ctrl.sv
// Sleep controller end: register pair, sleep state machine, clock gates,
// wake-up source selection and wake delays.
// Assumes peripheral interrupt inputs are on the system clock, external
// interrupt pins are asynchronous, and fuses/signature are static.
`timescale 1ns/1ns

// Notes on behaviour
// [RQ1] Factory 1MHz trim byte loaded at reset
// [RQ2] Trim zero slowest, larger faster, FF fastest
// [RQ3] Trim spans about half to double nominal
// [RQ4] Software avoids fast trim during memory writes
// [RQ5] Sleep needs arm bit plus sleep instruction
// [RQ6] Interrupt wake halts four extra cycles
// [RQ7] Memory kept; reset wakes to reset vector
// [RQ8] Idle stops only core and program clocks
// [RQ9] Idle wakes on any interrupt
// [RQ10] Idle or noise mode starts a conversion
// [RQ11] Noise mode also stops peripheral clock
// [RQ12] Noise mode wake sources limited list
// [RQ13] Power-down stops oscillator and all clocks
// [RQ14] Power-down wake sources limited list
// [RQ15] Level wake source holds level long enough
// [RQ16] Power-down wake waits fuse-selected restart delay
// [RQ17] Power-save keeps async timer clock running
// [RQ18] Timer 2 wake needs mask and global enable
// [RQ19] Software uses power-down without async timer
// [RQ20] Standby modes keep oscillator; crystal only
// [RQ21] Deep modes: only irq2 or level irq0/1
// [RQ22] Standby codes 110/111, six cycle wake
// [RQ23] Arm bit 7, mode bits 6:4, reset zero
// [RQ24] Unarmed sleep instruction is a no-operation
module sccg_ctrl
	import sccg_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	sccg_link_if.dev link,
	input wire logic [7:0] sig_row_hi_i,
	input wire logic [3:0] clock_select_fuses_i,
	input wire logic ext_irq_0_pin_i,
	input wire logic ext_irq_1_pin_i,
	input wire logic ext_irq_2_pin_i,
	input wire logic ext_irq_0_level_i,
	input wire logic ext_irq_1_level_i,
	input wire logic twi_match_irq_i,
	input wire logic timer2_ovf_irq_i,
	input wire logic timer2_cmp_irq_i,
	input wire logic timer2_ovf_en_i,
	input wire logic timer2_cmp_en_i,
	input wire logic timer2_async_select_i,
	input wire logic adc_done_irq_i,
	input wire logic adc_enable_i,
	input wire logic mem_ready_irq_i,
	input wire logic other_io_irq_i,
	output logic core_clock_en_o,
	output logic program_mem_clock_en_o,
	output logic peripheral_clock_en_o,
	output logic converter_clock_en_o,
	output logic async_timer_clock_en_o,
	output logic main_osc_en_o,
	output logic adc_start_o,
	output logic [7:0] rc_oscillator_trim_o,
	output logic sleeping_o
);

	typedef enum logic [1:0] {
		SCCG_RUN = 2'b00,
		SCCG_SLEEP = 2'b01,
		SCCG_RESTART = 2'b10,
		SCCG_HALT = 2'b11
	} sccg_state_t;

	////////////////////////////////////////////////////////////////////////
	// External interrupt pin synchronisers

	logic [2:0] pin_meta_ff;
	logic [2:0] pin_sync_ff;
	logic [2:0] pin_raw;

	assign pin_raw = {ext_irq_2_pin_i, ext_irq_1_pin_i, ext_irq_0_pin_i};

	// Two flops per pin; only the second stage is looked at
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					pin_meta_ff[gi] <= 1'b0;
					pin_sync_ff[gi] <= 1'b0;
				end else begin
					pin_meta_ff[gi] <= pin_raw[gi];
					pin_sync_ff[gi] <= pin_meta_ff[gi];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Wake-up source selection

	logic timer2_wake;
	logic ext_any;
	logic ext_deep;
	logic wake_hit;
	logic crystal_sel;
	sccg_state_t state_ff;
	sccg_mode_t mode_ff;
	logic [3:0] fuses_ff;

	assign timer2_wake = ((timer2_ovf_irq_i & timer2_ovf_en_i)
		| (timer2_cmp_irq_i & timer2_cmp_en_i)) & link.irq_global_en; // RQ18
	assign ext_any = |pin_sync_ff;
	// Edge-type irq0/irq1 cannot wake anything deeper than idle
	assign ext_deep = pin_sync_ff[2] | (pin_sync_ff[0] & ext_irq_0_level_i)
		| (pin_sync_ff[1] & ext_irq_1_level_i); // RQ21
	assign crystal_sel = fuses_ff > SCCG_FUSE_EXTRC_LAST;

	// Per-mode wake mask
	always_comb begin
		wake_hit = 1'b0;
		unique case (mode_ff)
			SCCG_IDLE: begin
				wake_hit = ext_any | twi_match_irq_i | timer2_wake
					| mem_ready_irq_i | adc_done_irq_i | other_io_irq_i; // RQ9
			end
			SCCG_ADC_NR: begin
				wake_hit = adc_done_irq_i | twi_match_irq_i | timer2_wake
					| mem_ready_irq_i | ext_deep; // RQ12
			end
			SCCG_PWR_SAVE, SCCG_EXT_STANDBY: begin
				wake_hit = twi_match_irq_i | ext_deep
					| (timer2_async_select_i & timer2_wake); // RQ17 RQ18
			end
			default: begin
				wake_hit = twi_match_irq_i | ext_deep; // RQ14
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Registers and sleep state machine

	logic arm_ff;
	logic [2:0] mode_sel_ff;
	logic [7:0] trim_ff;
	logic loaded_ff;
	logic [10:0] cnt_ff;
	logic [7:0] rdata_ff;
	logic rvalid_ff;
	logic adc_start_ff;
	logic go_ff;
	logic [5:0] gate_ff;
	logic nxt_arm;
	logic [2:0] nxt_mode_sel;
	logic [7:0] nxt_trim;
	logic nxt_loaded;
	logic [3:0] nxt_fuses;
	sccg_state_t nxt_state;
	sccg_mode_t nxt_mode;
	logic [10:0] nxt_cnt;
	logic [7:0] nxt_rdata;
	logic nxt_rvalid;
	logic nxt_adc_start;
	logic nxt_go;
	logic [5:0] nxt_gate;
	logic [10:0] restart_ck;
	logic wr_ok;

	assign wr_ok = link.io_wr & (state_ff == SCCG_RUN);

	// Deep modes wait for the clock to restart, standby six cycles when a crystal is selected
	always_comb begin
		restart_ck = 11'h000;
		unique case (mode_ff)
			SCCG_PWR_DOWN, SCCG_PWR_SAVE: begin
				restart_ck = sccg_restart_ck(fuses_ff); // RQ16
			end
			SCCG_STANDBY, SCCG_EXT_STANDBY: begin
				restart_ck = crystal_sel ? SCCG_STANDBY_CK
					: sccg_restart_ck(fuses_ff); // RQ22
			end
			default: begin
				restart_ck = 11'h000;
			end
		endcase
	end

	// Next-state logic for registers, sequencing and gates
	always_comb begin
		nxt_arm = arm_ff;
		nxt_mode_sel = mode_sel_ff;
		nxt_trim = trim_ff;
		nxt_loaded = 1'b1;
		nxt_fuses = fuses_ff;
		nxt_state = state_ff;
		nxt_mode = mode_ff;
		nxt_cnt = cnt_ff;
		nxt_rdata = rdata_ff;
		nxt_rvalid = 1'b0;
		nxt_adc_start = 1'b0;
		nxt_go = 1'b0;
		// Strap capture on the first edge after reset release
		if (!loaded_ff) begin
			nxt_trim = sig_row_hi_i; // RQ1
			nxt_fuses = clock_select_fuses_i;
		end
		if (wr_ok && link.io_addr == SCCG_TRIM_OFS) begin
			nxt_trim = link.io_wdata; // RQ2
		end
		if (wr_ok && link.io_addr == SCCG_CTRL_OFS) begin
			nxt_arm = link.io_wdata[SCCG_ARM_BIT]; // RQ23
			nxt_mode_sel = link.io_wdata[SCCG_MODE_MSB:SCCG_MODE_LSB];
		end
		// Unmapped offsets read back as zero
		if (link.io_rd) begin
			nxt_rvalid = 1'b1;
			nxt_rdata = 8'h00;
			if (link.io_addr == SCCG_TRIM_OFS) begin
				nxt_rdata = trim_ff;
			end else if (link.io_addr == SCCG_CTRL_OFS) begin
				nxt_rdata = {arm_ff, mode_sel_ff, 4'h0} & SCCG_CTRL_MASK;
			end
		end
		unique case (state_ff)
			SCCG_RUN: begin
				// Reserved codes and unarmed sleeps are no-operations
				if (link.sleep_instr && arm_ff
					&& mode_sel_ff != SCCG_RSV4
					&& mode_sel_ff != SCCG_RSV5) begin // RQ5 RQ24
					nxt_state = SCCG_SLEEP;
					nxt_mode = sccg_mode_t'(mode_sel_ff);
					nxt_adc_start = adc_enable_i
						& (mode_sel_ff == SCCG_IDLE
						|| mode_sel_ff == SCCG_ADC_NR); // RQ10
				end
			end
			SCCG_SLEEP: begin
				if (wake_hit) begin
					if (restart_ck == 11'h000) begin
						nxt_state = SCCG_HALT;
						nxt_cnt = SCCG_HALT_CK - 11'h001; // RQ6
					end else begin
						nxt_state = SCCG_RESTART;
						nxt_cnt = restart_ck - 11'h001; // RQ16
					end
				end
			end
			SCCG_RESTART: begin
				nxt_cnt = cnt_ff - 11'h001;
				if (cnt_ff == 11'h000) begin
					nxt_state = SCCG_HALT;
					nxt_cnt = SCCG_HALT_CK - 11'h001; // RQ6
				end
			end
			SCCG_HALT: begin
				nxt_cnt = cnt_ff - 11'h001;
				if (cnt_ff == 11'h000) begin
					nxt_state = SCCG_RUN;
					nxt_go = 1'b1; // RQ6
				end
			end
		endcase
		// Gates: {osc, async, converter, peripheral, program, core}
		nxt_gate = 6'h3F;
		if (nxt_state == SCCG_SLEEP || nxt_state == SCCG_RESTART) begin
			unique case (nxt_mode)
				SCCG_IDLE: nxt_gate = 6'h3C; // RQ8
				SCCG_ADC_NR: nxt_gate = 6'h38; // RQ11
				SCCG_PWR_SAVE: begin
					nxt_gate = {1'b0, timer2_async_select_i, 4'h0}; // RQ17
				end
				SCCG_STANDBY: begin
					nxt_gate = {crystal_sel, 5'h00}; // RQ20 RQ22
				end
				SCCG_EXT_STANDBY: begin
					nxt_gate = {crystal_sel, timer2_async_select_i, 4'h0};
				end
				default: nxt_gate = 6'h00; // RQ13
			endcase
			// Oscillator comes back first while the delay runs
			if (nxt_state == SCCG_RESTART) begin
				nxt_gate[5] = 1'b1;
			end
		end
	end

	// Reset, from any source, returns straight to run; memory untouched
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_ff <= SCCG_RUN; // RQ7
			mode_ff <= SCCG_IDLE;
			arm_ff <= SCCG_CTRL_RST[SCCG_ARM_BIT];
			mode_sel_ff <= SCCG_CTRL_RST[SCCG_MODE_MSB:SCCG_MODE_LSB];
			trim_ff <= SCCG_TRIM_RST;
			loaded_ff <= 1'b0;
			fuses_ff <= 4'h0;
			cnt_ff <= 11'h000;
			rdata_ff <= 8'h00;
			rvalid_ff <= 1'b0;
			adc_start_ff <= 1'b0;
			go_ff <= 1'b0;
			gate_ff <= 6'h3F;
		end else begin
			state_ff <= nxt_state;
			mode_ff <= nxt_mode;
			arm_ff <= nxt_arm;
			mode_sel_ff <= nxt_mode_sel;
			trim_ff <= nxt_trim;
			loaded_ff <= nxt_loaded;
			fuses_ff <= nxt_fuses;
			cnt_ff <= nxt_cnt;
			rdata_ff <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
			adc_start_ff <= nxt_adc_start;
			go_ff <= nxt_go;
			gate_ff <= nxt_gate;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign core_clock_en_o = gate_ff[0];
	assign program_mem_clock_en_o = gate_ff[1];
	assign peripheral_clock_en_o = gate_ff[2];
	assign converter_clock_en_o = gate_ff[3];
	assign async_timer_clock_en_o = gate_ff[4];
	assign main_osc_en_o = gate_ff[5];
	assign adc_start_o = adc_start_ff;
	// Monotonic code straight to the oscillator; range is analog
	assign rc_oscillator_trim_o = trim_ff; // RQ2 RQ3
	assign sleeping_o = state_ff != SCCG_RUN;
	assign link.io_rdata = rdata_ff;
	assign link.io_rvalid = rvalid_ff;
	assign link.core_halt = state_ff != SCCG_RUN;
	assign link.handler_go = go_ff;
	assign link.factory_trim = sig_row_hi_i;
	assign link.timer_async = timer2_async_select_i;

endmodule

// file: sccg_core.sv
// CPU core end: issues register accesses and the sleep instruction,
// and guards trim and mode writes on behalf of software.
// Assumes the sleep controller answers reads one cycle after the strobe.
`timescale 1ns/1ns
module sccg_core
	import sccg_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	sccg_link_if.core link,
	input wire logic req_wr_i,
	input wire logic req_rd_i,
	input wire logic [5:0] req_addr_i,
	input wire logic [7:0] req_wdata_i,
	input wire logic sleep_req_i,
	input wire logic nvm_busy_i,
	input wire logic irq_global_en_i,
	output logic req_ready_o,
	output logic [7:0] rd_data_o,
	output logic rd_valid_o,
	output logic reject_o,
	output logic halted_o,
	output logic handler_go_o
);

	////////////////////////////////////////////////////////////////////////
	// Request guard and strobe registers

	logic wr_ff;
	logic rd_ff;
	logic sleep_ff;
	logic [5:0] addr_ff;
	logic [7:0] wdata_ff;
	logic reject_ff;
	logic [7:0] rdata_ff;
	logic rvalid_ff;
	logic go_ff;
	logic nxt_wr;
	logic nxt_rd;
	logic nxt_sleep;
	logic [5:0] nxt_addr;
	logic [7:0] nxt_wdata;
	logic nxt_reject;
	logic [7:0] nxt_rdata;
	logic nxt_rvalid;
	logic [8:0] trim_limit;
	logic too_fast;
	logic busy;

	// Stalled while asleep or while a sleep strobe is still on the link
	assign busy = link.core_halt | sleep_ff;
	assign req_ready_o = ~busy;
	assign trim_limit = {1'b0, link.factory_trim}
		+ {1'b0, SCCG_TRIM_FAST_MARGIN};
	assign too_fast = {1'b0, req_wdata_i} > trim_limit;

	// Next values for strobes, with trim rejection and mode substitution
	always_comb begin
		nxt_wr = 1'b0;
		nxt_rd = 1'b0;
		nxt_sleep = 1'b0;
		nxt_addr = addr_ff;
		nxt_wdata = wdata_ff;
		nxt_reject = 1'b0;
		nxt_rdata = rdata_ff;
		nxt_rvalid = link.io_rvalid;
		if (link.io_rvalid) begin
			nxt_rdata = link.io_rdata;
		end
		if (!busy) begin
			if (sleep_req_i) begin
				nxt_sleep = 1'b1; // RQ5
			end else if (req_wr_i) begin
				nxt_addr = req_addr_i;
				nxt_wdata = req_wdata_i;
				nxt_wr = 1'b1;
				// Fast trim would upset oscillator-timed memory writes
				if (req_addr_i == SCCG_TRIM_OFS && nvm_busy_i && too_fast) begin
					nxt_wr = 1'b0; // RQ4
					nxt_reject = 1'b1;
				end
				// Without an async timer, power-save is swapped for power-down
				if (req_addr_i == SCCG_CTRL_OFS && !link.timer_async
					&& req_wdata_i[SCCG_MODE_MSB:SCCG_MODE_LSB]
					== SCCG_PWR_SAVE) begin
					nxt_wdata[SCCG_MODE_MSB:SCCG_MODE_LSB] = SCCG_PWR_DOWN; // RQ19
				end
			end else if (req_rd_i) begin
				nxt_addr = req_addr_i;
				nxt_rd = 1'b1;
			end
		end
	end

	// Strobe and answer registers
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ff <= 1'b0;
			rd_ff <= 1'b0;
			sleep_ff <= 1'b0;
			addr_ff <= 6'h00;
			wdata_ff <= 8'h00;
			reject_ff <= 1'b0;
			rdata_ff <= 8'h00;
			rvalid_ff <= 1'b0;
			go_ff <= 1'b0;
		end else begin
			wr_ff <= nxt_wr;
			rd_ff <= nxt_rd;
			sleep_ff <= nxt_sleep;
			addr_ff <= nxt_addr;
			wdata_ff <= nxt_wdata;
			reject_ff <= nxt_reject;
			rdata_ff <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
			go_ff <= link.handler_go; // RQ6
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign link.io_addr = addr_ff;
	assign link.io_wdata = wdata_ff;
	assign link.io_wr = wr_ff;
	assign link.io_rd = rd_ff;
	assign link.sleep_instr = sleep_ff;
	assign link.irq_global_en = irq_global_en_i;
	assign rd_data_o = rdata_ff;
	assign rd_valid_o = rvalid_ff;
	assign reject_o = reject_ff;
	assign halted_o = link.core_halt;
	assign handler_go_o = go_ff;

endmodule

// file: sccg_sva.sv
// Checker for the link between core end and sleep controller end.
// Assumes one system clock and the link signals seen as plain inputs.
`timescale 1ns/1ns
module sccg_sva
	import sccg_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [5:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_rdata,
	input wire logic io_rvalid,
	input wire logic sleep_instr,
	input wire logic irq_global_en,
	input wire logic core_halt,
	input wire logic handler_go,
	input wire logic [7:0] factory_trim,
	input wire logic timer_async
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	logic first_ff, nxt_first;
	logic [7:0] ctrl_ff, nxt_ctrl, trim_ff, nxt_trim;
	////////////////////////////////////////////////////////////////////
	// Shadow registers; writes count only in RUN, as the device ignores
	// them while asleep
	always_comb begin
		nxt_first = 1'b0;
		nxt_ctrl = ctrl_ff;
		nxt_trim = trim_ff;
		if (first_ff) begin
			nxt_trim = factory_trim;
		end else if (io_wr && !core_halt && io_addr == SCCG_TRIM_OFS) begin
			nxt_trim = io_wdata;
		end
		if (io_wr && !core_halt && io_addr == SCCG_CTRL_OFS) begin
			nxt_ctrl = io_wdata & SCCG_CTRL_MASK;
			if (nxt_ctrl[6:4] == 3'b011 && !timer_async) begin
				nxt_ctrl[4] = 1'b0;
			end
		end
	end
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			first_ff <= 1'b1;
			ctrl_ff <= 8'h00;
			trim_ff <= 8'h00;
		end else begin
			first_ff <= nxt_first;
			ctrl_ff <= nxt_ctrl;
			trim_ff <= nxt_trim;
		end
	end
	////////////////////////////////////////////////////////////////////
	// Halt must last at least five cycles: one sleep cycle and four halt cycles
	sequence s_halted;
		core_halt [*5];
	endsequence
	read_answer_a: assert property (io_rd |=> io_rvalid)
		else $error("read strobe not answered");
	ctrl_read_a: assert property (io_rd && io_addr == SCCG_CTRL_OFS
		|=> io_rdata == $past(ctrl_ff)) else $error("control readback");
	trim_read_a: assert property (io_rd && io_addr == SCCG_TRIM_OFS
		|=> io_rdata == $past(trim_ff)) else $error("trim readback");
	unmapped_read_a: assert property (io_rd && io_addr != SCCG_TRIM_OFS
		&& io_addr != SCCG_CTRL_OFS |=> io_rdata == 8'h00)
		else $error("unmapped read not zero");
	armed_sleep_a: assert property (sleep_instr && !core_halt &&
		ctrl_ff[7] && ctrl_ff[6:5] != 2'b10 |=> core_halt)
		else $error("armed sleep not entered");
	unarmed_nop_a: assert property (sleep_instr && !ctrl_ff[7]
		&& !core_halt |=> !core_halt) else $error("unarmed sleep halted");
	halt_min_a: assert property ($rose(core_halt) |-> s_halted)
		else $error("halt too short");
	wake_return_a: assert property ($fell(core_halt) |-> handler_go)
		else $error("halt ended without handler start");
	go_pulse_a: assert property (handler_go |-> !core_halt ##1 !handler_go)
		else $error("handler start not a single pulse");
endmodule

// file: sleep_clock_gating_ctrl_tb_top.sv
// Self-checking bench joining the core end and the controller end.
// Assumes the package and link interface are compiled first.
`timescale 1ns/1ns
module sleep_clock_gating_ctrl_tb_top
	import sccg_pkg::*;
;
	logic clk, rst_n, p0, p1, p2, l0, l1, two_wire_port, t2o, t2c, t2o_en, t2c_en;
	logic as2, adc_done, adc_en, mem_rdy, oth, wr, rd, slp, nvm, gie;
	logic [7:0] sig_row, wdata, d, t;
	logic [3:0] fz[3];
	logic [5:0] addr;
	wire logic ready, rd_valid, reject, halted, go, adc_start, sleeping;
	wire logic [7:0] rd_data, trim_o;
	wire logic [5:0] gates;
	int n_mismatch, n_compared, seed, cyc, k, lag;
	sccg_link_if i_sccg_link_if();
	sccg_ctrl i_sccg_ctrl(.sys_clk_i(clk), .rst_n_i(rst_n),
		.link(i_sccg_link_if), .sig_row_hi_i(sig_row),
		.clock_select_fuses_i(fz[0]), .ext_irq_0_pin_i(p0),
		.ext_irq_1_pin_i(p1), .ext_irq_2_pin_i(p2), .ext_irq_0_level_i(l0),
		.ext_irq_1_level_i(l1), .twi_match_irq_i(two_wire_port), .timer2_ovf_irq_i(t2o),
		.timer2_cmp_irq_i(t2c), .timer2_ovf_en_i(t2o_en),
		.timer2_cmp_en_i(t2c_en), .timer2_async_select_i(as2),
		.adc_done_irq_i(adc_done), .adc_enable_i(adc_en),
		.mem_ready_irq_i(mem_rdy), .other_io_irq_i(oth),
		.core_clock_en_o(gates[5]), .program_mem_clock_en_o(gates[4]),
		.peripheral_clock_en_o(gates[3]), .converter_clock_en_o(gates[2]),
		.async_timer_clock_en_o(gates[1]), .main_osc_en_o(gates[0]),
		.adc_start_o(adc_start), .rc_oscillator_trim_o(trim_o),
		.sleeping_o(sleeping));
	sccg_core i_sccg_core(.sys_clk_i(clk), .rst_n_i(rst_n),
		.link(i_sccg_link_if), .req_wr_i(wr), .req_rd_i(rd),
		.req_addr_i(addr), .req_wdata_i(wdata), .sleep_req_i(slp),
		.nvm_busy_i(nvm), .irq_global_en_i(gie), .req_ready_o(ready),
		.rd_data_o(rd_data), .rd_valid_o(rd_valid), .reject_o(reject),
		.halted_o(halted), .handler_go_o(go));
	sccg_sva i_sccg_sva(.sys_clk_i(clk), .rst_n_i(rst_n),
		.io_addr(i_sccg_link_if.io_addr), .io_wdata(i_sccg_link_if.io_wdata),
		.io_wr(i_sccg_link_if.io_wr), .io_rd(i_sccg_link_if.io_rd),
		.io_rdata(i_sccg_link_if.io_rdata),
		.io_rvalid(i_sccg_link_if.io_rvalid),
		.sleep_instr(i_sccg_link_if.sleep_instr),
		.irq_global_en(i_sccg_link_if.irq_global_en),
		.core_halt(i_sccg_link_if.core_halt),
		.handler_go(i_sccg_link_if.handler_go),
		.factory_trim(i_sccg_link_if.factory_trim),
		.timer_async(i_sccg_link_if.timer_async));
	////////////////////////////////////////////////////////////////////
	// Clock and hang guard; the deepest wakes take about 1k cycles each
	initial clk = 1'b0;
	always #10 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_mismatch++;
			results();
		end
	end
	////////////////////////////////////////////////////////////////////
	// Expectations: gates {core, prog, periph, conv, async, osc}
	function automatic logic [5:0] exp_gates(int m, logic [3:0] f, logic a);
		return {2'b00, m == 0, m <= 1, m <= 1 || ((m == 3 || m == 7) && a),
			m <= 1 || (m >= 6 && f > 4'h8)};
	endfunction
	function automatic int exp_delay(int m, logic [3:0] f);
		if (m <= 1) return 0;
		if ((m >= 6 && f > 4'h8) || f <= 4'h4) return 6;
		return (f <= 4'h8) ? 18 : 1024;
	endfunction
	function automatic logic [7:0] exp_ctrl(logic [7:0] v, logic a);
		v = v & 8'hF0;
		if (v[6:4] == 3'b011 && !a) v[4] = 1'b0;
		return v;
	endfunction
	////////////////////////////////////////////////////////////////////
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task results;
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task do_reset;
		@(negedge clk) rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
	endtask
	// One request held until the core is ready, dropped after its edge
	task req(input logic w, r, s, input logic [5:0] a, input logic [7:0] v);
		int n;
		n = 0;
		@(negedge clk);
		{wr, rd, slp, addr, wdata} = {w, r, s, a, v};
		while (ready !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		{wr, rd, slp} = 3'b000;
	endtask
	task rd_chk(input logic [5:0] a, input logic [7:0] e);
		req(0, 1, 0, a, 8'h00);
		repeat (2) @(negedge clk);
		chk(rd_valid, 1'b1);
		chk(rd_data, e);
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'h7632;
		{rst_n, p0, p1, p2, l0, l1, two_wire_port, t2o, t2c, t2o_en, t2c_en} = 11'h001;
		{as2, adc_done, adc_en, mem_rdy, oth, wr, rd, slp, nvm} = 9'h000;
		// Global enable on, so an enabled timer 2 event can wake the core
		gie = 1'b1;
		{addr, wdata, sig_row} = 22'h000000;
		cyc = 0;
		fz = '{4'h3, 4'h7, 4'hF};
		for (int p = 0; p < 3; p++) begin
			fz = '{fz[p], fz[1], fz[2]};
			sig_row = 8'($random(seed)) & 8'h7F;
			do_reset();
			rd_chk(SCCG_TRIM_OFS, sig_row);
			chk(trim_o, sig_row);
			rd_chk(SCCG_CTRL_OFS, SCCG_CTRL_RST);
			rd_chk(6'h20, 8'h00);
			t = 8'($random(seed));
			req(1, 0, 0, SCCG_TRIM_OFS, t);
			rd_chk(SCCG_TRIM_OFS, t);
			nvm = 1'b1;
			req(1, 0, 0, SCCG_TRIM_OFS, sig_row + 8'h1A);
			chk(reject, 1'b1);
			req(1, 0, 0, SCCG_TRIM_OFS, sig_row + 8'h19);
			chk(reject, 1'b0);
			nvm = 1'b0;
			rd_chk(SCCG_TRIM_OFS, sig_row + 8'h19);
			req(1, 0, 0, SCCG_CTRL_OFS, 8'h7F);
			req(0, 0, 1, 6'h00, 8'h00);
			@(negedge clk);
			chk(halted, 1'b0);
			for (int m = 0; m < 8; m++) begin
				{as2, adc_en, t2o_en} = {2'($random(seed)), 1'b0};
				d = {1'b1, 3'(m), 4'($random(seed))};
				req(1, 0, 0, SCCG_CTRL_OFS, d);
				rd_chk(SCCG_CTRL_OFS, exp_ctrl(d, as2));
				req(0, 0, 1, 6'h00, 8'h00);
				@(negedge clk);
				chk(halted, m != 4 && m != 5);
				chk(sleeping, m != 4 && m != 5);
				chk(ready, m == 4 || m == 5);
				if (m == 4 || m == 5) continue;
				chk(gates, exp_gates(m, fz[0], as2));
				chk(adc_start, adc_en && m <= 1);
				if (m >= 1) begin
					{oth, p0, p1, t2o, adc_done, mem_rdy} = {4'hF, m >= 2, m >= 2};
					@(negedge clk);
					{oth, p0, p1, t2o, adc_done, mem_rdy} = 6'h00;
					repeat (4) @(negedge clk);
					chk(halted, 1'b1);
				end
				lag = 0;
				if (m == 0) oth = 1'b1;
				else if (m == 1) adc_done = 1'b1;
				else if ((m == 3 || m == 7) && as2) {t2o_en, t2o} = 2'b11;
				else {p2, lag} = {1'b1, 32'd2};
				k = 0;
				while (go !== 1'b1 && k < 1200) begin
					@(negedge clk);
					k++;
				end
				{oth, adc_done, t2o, p2} = 4'h0;
				chk(16'(k), 16'(exp_delay(m, fz[0]) + 6 + lag));
				chk(gates, 6'h3F);
			end
		end
		// Reset arriving in power-down returns straight to running
		req(1, 0, 0, SCCG_CTRL_OFS, 8'hA0);
		req(0, 0, 1, 6'h00, 8'h00);
		@(negedge clk) rst_n = 1'b0;
		@(negedge clk);
		chk(halted, 1'b0);
		chk(gates, 6'h3F);
		@(negedge clk) rst_n = 1'b1;
		results();
	end
endmodule
